// [verilog/qsf_cmd_frame.sv]
// device-side instruction framer for four-wire command mode
// Summary of operation
// - opcode takes two clocks, high nibble first; address and data follow alike.
// - three-byte mode: 24-bit address in clocks two to seven.
// - four-byte mode: 32-bit address in clocks two to nine.
// - every byte moves most significant bit first.
// - status and identifier bytes repeat until chip select rises.
// - page program carries 1 to 256 bytes; overflow wraps to page start.
// - security register chosen by address 23..16 zero and 15..8 10h/20h/30h.
// - two-line address: odd bits on line 1, even bits on line 0.
// - two-line data out: bits 7,5,3,1 on line 1, 6,4,2,0 on line 0.
// - four-line address: each line every fourth bit, then mode bits.
// - wrap setting uses only seventh nibble, bits on lines 0..2.
// - four-line data moves high nibble then low nibble.
// - quad I/O read leaves four don't-care clocks after mode bits while read-parameter bits 7..4 are zero.
// - quad word read leaves two don't-care clocks before data.
// - fast and quad I/O read dummy clock count follows read-parameter bits 7..4.
// - wrapped read length follows read-parameter bits 1..0.
// - write-enable opcode sets the write-enable latch.
// - volatile write enable leaves latch alone, qualifies status write only.
// - latch clears at reset and when writes, erases or resets complete.
// - status read is accepted at any time, even while busy.
`include "qsf_regs.svh"
module qsf_cmd_frame
  import qsf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic linkClk,
  input wire logic chipSelN,
  input wire logic [3:0] dataLineIn,
  output logic [3:0] dataLineOut,
  output logic [3:0] dataLineOeN,
  input wire logic dualLines,
  input wire logic busy,
  input wire logic [5:0] statusUpper,
  input wire logic lockStatus,
  input wire logic [7:0] arrayData,
  output logic [31:0] arrayAddr,
  input wire logic opDone,
  output logic cmdStrobe,
  output logic [7:0] cmdOpcode,
  output logic [31:0] cmdAddr,
  output logic [1:0] secRegIndex,
  output logic statusWrite,
  output logic statusWriteVolatile,
  output logic [7:0] statusWriteData,
  output logic writeEnableLatch,
  output logic fourByteMode,
  output logic [3:0] dummyClockCountField,
  output logic [3:0] wrapLengthField,
  output logic [7:0] continuousReadModeBits,
  output logic [2:0] wrapSettingBits,
  output logic [7:0] pgmData,
  output logic [7:0] pgmOffset,
  output logic pgmValid,
  input wire logic pgmReady,
  output logic pgmOverrun
);
  logic [5:0] syncPins;
  logic sclkSync;
  logic csSyncN;
  logic [3:0] ioSync;
  logic sclkPrev_reg;
  logic csActivePrev_reg;
  logic csActive;
  logic sclkRise;
  logic sclkFall;
  logic sample;
  logic frameStart;
  logic frameEnd;
  qsf_state_t state_reg;
  logic [7:0] opcode_reg;
  logic opValid_reg;
  logic [31:0] shift_reg;
  logic [5:0] bitCnt_reg;
  logic addrDone_reg;
  logic [3:0] dummyLeft_reg;
  logic byteSeen_reg;
  logic [7:0] dataByte_reg;
  logic wrapSeen_reg;
  logic [2:0] wrapCapture_reg;
  logic volEnable_reg;
  logic resetArmed_reg;
  logic [7:0] tx_reg;
  logic [3:0] txBits_reg;
  logic [5:0] step;
  logic [31:0] shiftIn;
  logic [5:0] bitsNext;
  logic [5:0] addrBits;
  logic [3:0] effDummy;
  logic [7:0] outSrc;
  logic [7:0] txCur;
  logic [3:0] txBitsNext;
  logic byteDoneIn;
  logic byteDoneOut;
  logic fifoInValid;
  logic fifoInReady;
  logic [15:0] fifoOut;
  logic [7:0] wrapMask;
  logic endOk;
  logic softReset;

  qsf_pin_sync #(.WIDTH(`QSF_SYNC_WIDTH), .RST_VAL(`QSF_SYNC_RESET)) u_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .asyncIn({linkClk, chipSelN, dataLineIn}),
    .syncOut(syncPins)
  );

  assign {sclkSync, csSyncN, ioSync} = syncPins;
  assign csActive = ~csSyncN;
  assign sclkRise = sclkSync & ~sclkPrev_reg;
  assign sclkFall = ~sclkSync & sclkPrev_reg;
  assign sample = sclkRise & csActive;
  assign frameStart = csActive & ~csActivePrev_reg;
  assign frameEnd = csActivePrev_reg & ~csActive;
  assign endOk = frameEnd & opValid_reg;
  assign softReset = endOk && opcode_reg == `QSF_OP_RST && resetArmed_reg;

  function automatic logic isAddressed(input logic [7:0] op);
    case (op)
      `QSF_OP_PAGE_PGM, `QSF_OP_ERASE_4K, `QSF_OP_ERASE_32K, `QSF_OP_ERASE_64K,
      `QSF_OP_FAST_RD, `QSF_OP_WRAP_RD, `QSF_OP_QIO_RD, `QSF_OP_WORD_RD,
      `QSF_OP_OCT_RD, `QSF_OP_BLK_LOCK, `QSF_OP_BLK_UNLOCK, `QSF_OP_RD_LOCK:
        return 1'b1;
      default:
        return 1'b0;
    endcase
  endfunction

  always_comb
  begin
    step = (dualLines && state_reg != ST_OPCODE) ? 6'h02 : 6'h04;
    // msb-first shift; dual puts odd bit on line 1, quad every fourth bit per line
    shiftIn = (step == 6'h02) ? {shift_reg[29:0], ioSync[1:0]} : {shift_reg[27:0], ioSync};
    bitsNext = bitCnt_reg + step;
    addrBits = fourByteMode ? `QSF_ADDR4_BITS : `QSF_ADDR3_BITS;
    case (opcode_reg)
      `QSF_OP_FAST_RD, `QSF_OP_WRAP_RD:
        effDummy = (dummyClockCountField != 4'h0) ? dummyClockCountField : `QSF_DUMMY_FAST;
      `QSF_OP_QIO_RD:
        effDummy = (dummyClockCountField != 4'h0) ? dummyClockCountField : `QSF_DUMMY_QIO;
      `QSF_OP_WORD_RD:
        effDummy = `QSF_DUMMY_WORD;
      default:
        effDummy = `QSF_DUMMY_OCT;
    endcase
    case (opcode_reg)
      `QSF_OP_RD_STAT:
        outSrc = {statusUpper, writeEnableLatch, busy};
      `QSF_OP_READ_ID:
        outSrc = `QSF_DEVICE_ID;
      `QSF_OP_RD_LOCK:
        outSrc = {7'h00, lockStatus};
      default:
        outSrc = arrayData;
    endcase
    case (wrapLengthField[1:0])
      2'h0: wrapMask = 8'h07;
      2'h1: wrapMask = 8'h0f;
      2'h2: wrapMask = 8'h1f;
      default: wrapMask = 8'h3f;
    endcase
  end

  assign byteDoneIn = sample && state_reg == ST_DIN && opcode_reg != `QSF_OP_SET_WRAP
    && bitsNext == `QSF_BYTE_BITS;
  assign txCur = (txBits_reg == 4'h0) ? outSrc : tx_reg;
  assign txBitsNext = txBits_reg + step[3:0];
  assign byteDoneOut = sclkFall && csActive && state_reg == ST_DOUT && txBitsNext == `QSF_TX_BYTE_BITS;

  // link edge and frame tracking
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclkPrev_reg <= 1'b0;
      csActivePrev_reg <= 1'b0;
    end
    else
    begin
      sclkPrev_reg <= sclkSync;
      csActivePrev_reg <= csActive;
    end
  end

  // frame state machine on rising link edges
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      opcode_reg <= 8'h00;
      opValid_reg <= 1'b0;
      shift_reg <= 32'h0;
      bitCnt_reg <= 6'h00;
      addrDone_reg <= 1'b0;
      dummyLeft_reg <= 4'h0;
      continuousReadModeBits <= 8'h00;
    end
    else if (!csActive)
    begin
      state_reg <= ST_IDLE;
    end
    else if (frameStart)
    begin
      state_reg <= ST_OPCODE;
      opValid_reg <= 1'b0;
      addrDone_reg <= 1'b0;
      bitCnt_reg <= 6'h00;
    end
    else if (sample)
    begin
      shift_reg <= shiftIn;
      case (state_reg)
        ST_OPCODE:
        begin
          if (bitCnt_reg != `QSF_OPCODE_HI_BITS)
            bitCnt_reg <= `QSF_OPCODE_HI_BITS;
          else
          begin
            opcode_reg <= shiftIn[7:0];
            opValid_reg <= 1'b1;
            bitCnt_reg <= 6'h00;
            if (isAddressed(shiftIn[7:0]))
              state_reg <= ST_ADDR;
            else if (shiftIn[7:0] == `QSF_OP_RD_STAT || shiftIn[7:0] == `QSF_OP_READ_ID)
              state_reg <= ST_DOUT;
            else if (shiftIn[7:0] == `QSF_OP_WR_STAT || shiftIn[7:0] == `QSF_OP_SET_PARAM
              || shiftIn[7:0] == `QSF_OP_SET_WRAP)
              state_reg <= ST_DIN;
            else
              state_reg <= ST_SKIP;
          end
        end
        ST_ADDR:
        begin
          bitCnt_reg <= bitsNext;
          if (bitsNext == addrBits)
          begin
            addrDone_reg <= 1'b1;
            bitCnt_reg <= 6'h00;
            case (opcode_reg)
              `QSF_OP_PAGE_PGM:
                state_reg <= ST_DIN;
              `QSF_OP_QIO_RD, `QSF_OP_WORD_RD, `QSF_OP_OCT_RD:
                state_reg <= ST_MODE;
              `QSF_OP_FAST_RD, `QSF_OP_WRAP_RD:
                state_reg <= (effDummy == 4'h0) ? ST_DOUT : ST_DUMMY;
              `QSF_OP_RD_LOCK:
                state_reg <= ST_DOUT;
              default:
                state_reg <= ST_SKIP;
            endcase
            dummyLeft_reg <= effDummy;
          end
        end
        ST_MODE:
        begin
          bitCnt_reg <= bitsNext;
          if (bitsNext == `QSF_BYTE_BITS)
          begin
            continuousReadModeBits <= shiftIn[7:0];
            bitCnt_reg <= 6'h00;
            state_reg <= (dummyLeft_reg == 4'h0) ? ST_DOUT : ST_DUMMY;
          end
        end
        ST_DUMMY:
        begin
          dummyLeft_reg <= dummyLeft_reg - 4'h1;
          if (dummyLeft_reg == 4'h1)
            state_reg <= ST_DOUT;
        end
        ST_DIN:
        begin
          if (opcode_reg == `QSF_OP_SET_WRAP)
            bitCnt_reg <= (bitCnt_reg == `QSF_WRAP_SAT_BITS) ? bitCnt_reg : bitsNext;
          else
            bitCnt_reg <= (bitsNext == `QSF_BYTE_BITS) ? 6'h00 : bitsNext;
        end
        default:
          state_reg <= state_reg;
      endcase
    end
  end

  // data bytes, wrap nibble and page overrun flag capture
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      byteSeen_reg <= 1'b0;
      dataByte_reg <= 8'h00;
      wrapSeen_reg <= 1'b0;
      wrapCapture_reg <= 3'h0;
      pgmOverrun <= 1'b0;
    end
    else if (frameStart)
    begin
      byteSeen_reg <= 1'b0;
      wrapSeen_reg <= 1'b0;
      pgmOverrun <= 1'b0;
    end
    else
    begin
      if (byteDoneIn)
      begin
        byteSeen_reg <= 1'b1;
        if (!byteSeen_reg)
          dataByte_reg <= shiftIn[7:0];
      end
      if (sample && state_reg == ST_DIN && opcode_reg == `QSF_OP_SET_WRAP
        && bitCnt_reg == `QSF_WRAP_NIBBLE_POS)
      begin
        wrapSeen_reg <= 1'b1;
        wrapCapture_reg <= ioSync[2:0];
      end
      if (fifoInValid && !fifoInReady)
        pgmOverrun <= 1'b1;
    end
  end

  // array address: page offset for program, auto-increment for reads
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      arrayAddr <= 32'h0;
    else if (sample && state_reg == ST_ADDR && bitsNext == addrBits)
      arrayAddr <= (addrBits == `QSF_ADDR3_BITS) ? {8'h00, shiftIn[23:0]} : shiftIn;
    else if (byteDoneIn)
      arrayAddr[7:0] <= arrayAddr[7:0] + 8'h01;
    else if (byteDoneOut && opcode_reg == `QSF_OP_WRAP_RD)
      arrayAddr[7:0] <= (arrayAddr[7:0] & ~wrapMask)
        | ((arrayAddr[7:0] + 8'h01) & wrapMask);
    else if (byteDoneOut && isAddressed(opcode_reg) && opcode_reg != `QSF_OP_RD_LOCK)
      arrayAddr <= arrayAddr + 32'h1;
  end

  // output lanes updated on falling link edges
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dataLineOut <= 4'h0;
      dataLineOeN <= 4'hf;
      tx_reg <= 8'h00;
      txBits_reg <= 4'h0;
    end
    else if (!csActive || state_reg != ST_DOUT)
    begin
      dataLineOeN <= 4'hf;
      txBits_reg <= 4'h0;
    end
    else if (sclkFall)
    begin
      if (dualLines)
      begin
        dataLineOut <= {2'b00, txCur[7:6]};
        tx_reg <= {txCur[5:0], 2'b00};
        dataLineOeN <= 4'hc;
      end
      else
      begin
        dataLineOut <= txCur[7:4];
        tx_reg <= {txCur[3:0], 4'h0};
        dataLineOeN <= 4'h0;
      end
      txBits_reg <= (txBitsNext == `QSF_TX_BYTE_BITS) ? 4'h0 : txBitsNext;
    end
  end

  // write-enable latch; a set in the same cycle as a clear wins
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      writeEnableLatch <= 1'b0;
    else if (endOk && opcode_reg == `QSF_OP_WREN)
      writeEnableLatch <= 1'b1;
    else if (opDone || softReset || (endOk && opcode_reg == `QSF_OP_WRDIS))
      writeEnableLatch <= 1'b0;
  end

  // volatile enable and reset arming, each good for the next frame only
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      volEnable_reg <= 1'b0;
      resetArmed_reg <= 1'b0;
    end
    else if (endOk)
    begin
      volEnable_reg <= (opcode_reg == `QSF_OP_VOL_WREN) && !softReset;
      resetArmed_reg <= opcode_reg == `QSF_OP_RST_EN;
    end
  end

  // configuration set by complete frames
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fourByteMode <= 1'b0;
      dummyClockCountField <= 4'h0;
      wrapLengthField <= 4'h0;
      wrapSettingBits <= 3'h0;
    end
    else if (softReset)
    begin
      fourByteMode <= 1'b0;
      dummyClockCountField <= 4'h0;
      wrapLengthField <= 4'h0;
    end
    else if (endOk)
    begin
      if (opcode_reg == `QSF_OP_ENTER_4B)
        fourByteMode <= 1'b1;
      if (opcode_reg == `QSF_OP_EXIT_4B)
        fourByteMode <= 1'b0;
      if (opcode_reg == `QSF_OP_SET_PARAM && byteSeen_reg)
      begin
        dummyClockCountField <= dataByte_reg[7:4];
        wrapLengthField <= dataByte_reg[3:0];
      end
      if (opcode_reg == `QSF_OP_SET_WRAP && wrapSeen_reg)
        wrapSettingBits <= wrapCapture_reg;
    end
  end

  // command and status-write strobes at frame end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmdStrobe <= 1'b0;
      cmdOpcode <= 8'h00;
      cmdAddr <= 32'h0;
      secRegIndex <= 2'h0;
      statusWrite <= 1'b0;
      statusWriteVolatile <= 1'b0;
      statusWriteData <= 8'h00;
    end
    else
    begin
      cmdStrobe <= 1'b0;
      statusWrite <= 1'b0;
      if (endOk && addrDone_reg)
      begin
        case (opcode_reg)
          `QSF_OP_ERASE_4K, `QSF_OP_ERASE_32K, `QSF_OP_ERASE_64K:
            cmdStrobe <= writeEnableLatch;
          `QSF_OP_PAGE_PGM:
            cmdStrobe <= writeEnableLatch && byteSeen_reg;
          `QSF_OP_BLK_LOCK, `QSF_OP_BLK_UNLOCK:
            cmdStrobe <= 1'b1;
          default:
            cmdStrobe <= 1'b0;
        endcase
        cmdOpcode <= opcode_reg;
        cmdAddr <= arrayAddr;
        if (arrayAddr[23:16] != `QSF_SECREG_TOP)
          secRegIndex <= 2'h0;
        else if (arrayAddr[15:8] == `QSF_SECREG1)
          secRegIndex <= 2'h1;
        else if (arrayAddr[15:8] == `QSF_SECREG2)
          secRegIndex <= 2'h2;
        else if (arrayAddr[15:8] == `QSF_SECREG3)
          secRegIndex <= 2'h3;
        else
          secRegIndex <= 2'h0;
      end
      if (endOk && opcode_reg == `QSF_OP_WR_STAT && byteSeen_reg
        && (writeEnableLatch || volEnable_reg))
      begin
        statusWrite <= 1'b1;
        statusWriteVolatile <= !writeEnableLatch;
        statusWriteData <= dataByte_reg;
      end
    end
  end

  assign fifoInValid = byteDoneIn && opcode_reg == `QSF_OP_PAGE_PGM && writeEnableLatch;

  qsf_fifo #(.WIDTH(`QSF_FIFO_WIDTH), .DEPTH(`QSF_FIFO_DEPTH)) u_pgm_fifo (
    .clk(ref_clk),
    .rst_n(rst_n),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData({arrayAddr[7:0], shiftIn[7:0]}),
    .outValid(pgmValid),
    .outReady(pgmReady),
    .outData(fifoOut)
  );

  assign pgmOffset = fifoOut[15:8];
  assign pgmData = fifoOut[7:0];
endmodule

// [verilog/qsf_regs.svh]
// opcodes, field widths, counts and defaults of the four-wire command framer
`ifndef QSF_REGS_SVH
`define QSF_REGS_SVH
`define QSF_OP_WREN 8'h06
`define QSF_OP_VOL_WREN 8'h50
`define QSF_OP_WRDIS 8'h04
`define QSF_OP_RD_STAT 8'h05
`define QSF_OP_WR_STAT 8'h01
`define QSF_OP_SET_PARAM 8'hc0
`define QSF_OP_ENTER_4B 8'hb7
`define QSF_OP_EXIT_4B 8'he9
`define QSF_OP_RST_EN 8'h66
`define QSF_OP_RST 8'h99
`define QSF_OP_READ_ID 8'h9f
`define QSF_OP_PAGE_PGM 8'h02
`define QSF_OP_ERASE_4K 8'h20
`define QSF_OP_ERASE_32K 8'h52
`define QSF_OP_ERASE_64K 8'hd8
`define QSF_OP_FAST_RD 8'h0b
`define QSF_OP_WRAP_RD 8'h0c
`define QSF_OP_QIO_RD 8'heb
`define QSF_OP_WORD_RD 8'he7
`define QSF_OP_OCT_RD 8'he3
`define QSF_OP_BLK_LOCK 8'h36
`define QSF_OP_BLK_UNLOCK 8'h39
`define QSF_OP_RD_LOCK 8'h3d
`define QSF_OP_SET_WRAP 8'h77
`define QSF_OPCODE_HI_BITS 6'h04
`define QSF_ADDR3_BITS 6'h18
`define QSF_ADDR4_BITS 6'h20
`define QSF_BYTE_BITS 6'h08
`define QSF_TX_BYTE_BITS 4'h8
`define QSF_WRAP_NIBBLE_POS 6'h18
`define QSF_WRAP_SAT_BITS 6'h20
`define QSF_DUMMY_FAST 4'h2
`define QSF_DUMMY_QIO 4'h4
`define QSF_DUMMY_WORD 4'h2
`define QSF_DUMMY_OCT 4'h0
`define QSF_SECREG_TOP 8'h00
`define QSF_SECREG1 8'h10
`define QSF_SECREG2 8'h20
`define QSF_SECREG3 8'h30
// identifier value is arbitrary
`define QSF_DEVICE_ID 8'h5a
`define QSF_FIFO_WIDTH 16
`define QSF_FIFO_DEPTH 32
`define QSF_SYNC_WIDTH 6
`define QSF_SYNC_RESET 6'h10
`endif

// [verilog/qsf_pkg.sv]
// types shared by the four-wire command framer
package qsf_pkg;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_OPCODE = 8'h02,
    ST_ADDR = 8'h04,
    ST_MODE = 8'h08,
    ST_DUMMY = 8'h10,
    ST_DIN = 8'h20,
    ST_DOUT = 8'h40,
    ST_SKIP = 8'h80
  } qsf_state_t;
endpackage

// [verilog/qsf_pin_sync.sv]
// two-flop synchroniser for pins from outside the clock domain
module qsf_pin_sync #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_reg <= RST_VAL;
      syncOut <= RST_VAL;
    end
    else
    begin
      stage1_reg <= asyncIn;
      syncOut <= stage1_reg;
    end
  end
endmodule

// [verilog/qsf_fifo.sv]
// flop-based fifo with valid/ready on both sides
module qsf_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_reg;
  logic [AW:0] rdPtr_reg;
  logic push;
  logic pop;

  assign inReady = (wrPtr_reg[AW] == rdPtr_reg[AW]) || (wrPtr_reg[AW-1:0] != rdPtr_reg[AW-1:0]);
  assign outValid = wrPtr_reg != rdPtr_reg;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem[rdPtr_reg[AW-1:0]];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_entry
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          mem[i] <= '0;
        else if (push && wrPtr_reg[AW-1:0] == AW'(i))
          mem[i] <= inData;
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end
    else
    begin
      if (push)
        wrPtr_reg <= wrPtr_reg + 1'b1;
      if (pop)
        rdPtr_reg <= rdPtr_reg + 1'b1;
    end
  end
endmodule

// [tb/qsf_cmd_frame_properties.sv]
// port checks of the four-wire command framer
module qsf_cmd_frame_chk
  import qsf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic chipSelN,
  input wire logic [3:0] dataLineOeN,
  input wire logic opDone,
  input wire logic cmdStrobe,
  input wire logic [7:0] cmdOpcode,
  input wire logic statusWrite,
  input wire logic statusWriteVolatile,
  input wire logic writeEnableLatch,
  input wire logic pgmValid,
  input wire logic pgmReady,
  input wire logic [7:0] pgmData,
  input wire logic [7:0] pgmOffset
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_open;
    $fell(chipSelN);
  endsequence
  sequence s_close;
    $rose(chipSelN);
  endsequence
  AST_QUIET_OPCODE: assert property (s_open |-> (dataLineOeN == 4'hf) [*8])
    else $error("lines driven in opcode");
  AST_RELEASE: assert property (s_close |-> ##[0:4] (dataLineOeN == 4'hf))
    else $error("lines held after frame");
  AST_LINE_SET: assert property (dataLineOeN inside {4'hf, 4'h0, 4'hc})
    else $error("bad line enable set");
  AST_STB_OPS:
    assert property (cmdStrobe |-> cmdOpcode inside {8'h02, 8'h20, 8'h52, 8'hd8, 8'h36, 8'h39})
    else $error("strobe with bad opcode");
  AST_STB_WEL:
    assert property (cmdStrobe && cmdOpcode inside {8'h02, 8'h20, 8'h52, 8'hd8}
      |-> $past(writeEnableLatch))
    else $error("write strobe without latch");
  AST_SW_VOL:
    assert property (statusWrite |-> statusWriteVolatile == !$past(writeEnableLatch))
    else $error("status write kind wrong");
  AST_WEL_CLR: assert property (opDone && $past(chipSelN, 4) |=> !writeEnableLatch)
    else $error("latch kept after done");
  AST_FIFO_HOLD:
    assert property (pgmValid && !pgmReady |=> pgmValid && $stable(pgmData) && $stable(pgmOffset))
    else $error("fifo head moved while stalled");
endmodule

bind qsf_cmd_frame qsf_cmd_frame_chk u_qsf_cmd_frame_chk (.ref_clk, .rst_n, .chipSelN,
  .dataLineOeN, .opDone, .cmdStrobe, .cmdOpcode, .statusWrite, .statusWriteVolatile,
  .writeEnableLatch, .pgmValid, .pgmReady, .pgmData, .pgmOffset);

// [tb/qsf_host_model.sv]
// host controller model for the four-wire link
module qsf_host_model (
  input wire logic ref_clk,
  input wire logic [3:0] devLine,
  output logic linkClk,
  output logic chipSelN,
  output logic [3:0] hostLine
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    linkClk = 1'b0;
    chipSelN = 1'b1;
    hostLine = 4'h0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic open_f();
    wt(1);
    chipSelN <= 1'b0;
    wt(3);
  endtask
  // data set while clock low, taken at the rise
  task automatic x(input logic [3:0] v, output logic [3:0] r);
    hostLine <= v;
    wt(4);
    linkClk <= 1'b1;
    r = devLine;
    wt(4);
    linkClk <= 1'b0;
  endtask
  task automatic b(input logic [7:0] v, output logic [7:0] r);
    logic [3:0] h;
    logic [3:0] l;
    x(v[7:4], h);
    x(v[3:0], l);
    r = {h, l};
  endtask
  // lines stop showing the last value after the frame
  task automatic close_f();
    wt(4);
    chipSelN <= 1'b1;
    hostLine <= ~hostLine;
    wt(8);
  endtask
endmodule

// [tb/tb_top.sv]
// self-checking bench for the four-wire command framer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, linkClk, chipSelN, dualLines, busy, lockStatus, opDone, pgmReady;
  logic cmdStrobe, statusWrite, statusWriteVolatile, writeEnableLatch, fourByteMode;
  logic pgmValid, pgmOverrun;
  logic [1:0] secRegIndex;
  logic [2:0] wrapSettingBits;
  logic [3:0] hostLine, dataLineOut, dataLineOeN, dataLineIn, dummyClockCountField;
  logic [3:0] wrapLengthField, nb;
  logic [5:0] statusUpper;
  logic [7:0] arrayData, cmdOpcode, statusWriteData, continuousReadModeBits, pgmData;
  logic [7:0] pgmOffset, rd;
  logic [31:0] arrayAddr, cmdAddr;
  int n_errors = 0;
  int check_count = 0;
  int stbCnt = 0;
  int swCnt = 0;
  int s0;
  assign dataLineIn = (~dataLineOeN & dataLineOut) | (dataLineOeN & hostLine);
  assign arrayData = arrayAddr[7:0] ^ 8'h3c;
  qsf_cmd_frame u_qsf_cmd_frame (.ref_clk, .rst_n, .linkClk, .chipSelN, .dataLineIn,
    .dataLineOut, .dataLineOeN, .dualLines, .busy, .statusUpper, .lockStatus, .arrayData,
    .arrayAddr, .opDone, .cmdStrobe, .cmdOpcode, .cmdAddr, .secRegIndex, .statusWrite,
    .statusWriteVolatile, .statusWriteData, .writeEnableLatch, .fourByteMode,
    .dummyClockCountField, .wrapLengthField, .continuousReadModeBits, .wrapSettingBits,
    .pgmData, .pgmOffset, .pgmValid, .pgmReady, .pgmOverrun);
  qsf_host_model u_qsf_host_model (.ref_clk, .devLine(dataLineIn), .linkClk, .chipSelN,
    .hostLine);
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    stbCnt <= stbCnt + int'(cmdStrobe === 1'b1);
    swCnt <= swCnt + int'(statusWrite === 1'b1);
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic snd(input logic [7:0] q[$]);
    u_qsf_host_model.open_f();
    foreach (q[i])
      u_qsf_host_model.b(q[i], rd);
  endtask
  task automatic frm(input logic [7:0] q[$]);
    snd(q);
    u_qsf_host_model.close_f();
  endtask
  task automatic t_wel();
    frm({8'h06});
    chk("wel", writeEnableLatch, 1);
    frm({8'h04});
    chk("wel", writeEnableLatch, 0);
    s0 = swCnt;
    frm({8'h50});
    chk("vwel", writeEnableLatch, 0);
    frm({8'h01, 8'ha5});
    chk("sw", swCnt - s0, 1);
    chk("swv", statusWriteVolatile, 1);
    chk("swd", statusWriteData, 8'ha5);
    $display("test wel done");
  endtask
  task automatic t_stat();
    busy <= 1'b1;
    statusUpper <= 6'h2b;
    snd({8'h05});
    repeat (3)
    begin
      u_qsf_host_model.b(8'h00, rd);
      chk("st", rd, {6'h2b, 2'b01});
    end
    u_qsf_host_model.close_f();
    dualLines <= 1'b1;
    snd({8'h05});
    repeat (4)
    begin
      u_qsf_host_model.x(4'h0, nb);
      rd = {rd[5:0], nb[1:0]};
    end
    u_qsf_host_model.close_f();
    dualLines <= 1'b0;
    chk("dst", rd, {6'h2b, 2'b01});
    busy <= 1'b0;
    $display("test stat done");
  endtask
  task automatic t_sec();
    logic [7:0] op[5] = '{8'h20, 8'h52, 8'hd8, 8'h36, 8'h39};
    frm({8'h06});
    s0 = stbCnt;
    frm({8'h20, 8'h00});
    chk("short", stbCnt - s0, 0);
    for (int i = 0; i < 5; i++)
    begin
      frm({op[i], 8'h00, 8'(8'h10 * (i + 1)), 8'h05});
      chk("op", cmdOpcode, op[i]);
      chk("ad", cmdAddr, {16'h0000, 8'(8'h10 * (i + 1)), 8'h05});
      chk("sec", secRegIndex, (i < 3) ? i + 1 : 0);
    end
    chk("stb", stbCnt - s0, 5);
    frm({8'hb7});
    chk("4b", fourByteMode, 1);
    frm({8'h20, 8'h01, 8'h00, 8'h10, 8'h07});
    chk("ad4", cmdAddr, 32'h01001007);
    frm({8'he9});
    $display("test sec done");
  endtask
  task automatic t_pgm();
    pgmReady <= 1'b0;
    snd({8'h02, 8'h00, 8'h12, 8'hf0});
    for (int i = 0; i < 33; i++)
      u_qsf_host_model.b(8'(i), rd);
    u_qsf_host_model.close_f();
    chk("ovr", pgmOverrun, 1);
    chk("pop", cmdOpcode, 8'h02);
    pgmReady <= 1'b1;
    for (int i = 0; i < 32; i++)
    begin
      @(posedge ref_clk);
      chk("off", pgmOffset, 8'(8'hf0 + i));
      chk("dat", pgmData, 8'(i));
    end
    @(posedge ref_clk);
    chk("empty", pgmValid, 0);
    opDone <= 1'b1;
    @(posedge ref_clk);
    opDone <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("wclr", writeEnableLatch, 0);
    $display("test pgm done");
  endtask
  task automatic t_par();
    frm({8'hc0, 8'h63});
    chk("dum", dummyClockCountField, 6);
    chk("wrp", wrapLengthField, 3);
    frm({8'h77, 8'h00, 8'h00, 8'h00, 8'h50});
    chk("wset", wrapSettingBits, 3'h5);
    snd({8'heb, 8'h00, 8'h00, 8'h12, 8'h5a});
    repeat (6)
      u_qsf_host_model.x(4'h0, nb);
    u_qsf_host_model.b(8'h00, rd);
    chk("q0", rd, 8'h2e);
    u_qsf_host_model.b(8'h00, rd);
    chk("q1", rd, 8'h2f);
    u_qsf_host_model.close_f();
    chk("mode", continuousReadModeBits, 8'h5a);
    snd({8'he7, 8'h00, 8'h00, 8'h14, 8'h00});
    repeat (2)
      u_qsf_host_model.x(4'h0, nb);
    u_qsf_host_model.b(8'h00, rd);
    u_qsf_host_model.close_f();
    chk("w0", rd, 8'h28);
    $display("test par done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    rst_n = 1'b0;
    dualLines = 1'b0;
    lockStatus = 1'b0;
    busy = 1'b0;
    statusUpper = 6'h00;
    opDone = 1'b0;
    pgmReady = 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_wel();
    t_stat();
    t_sec();
    t_pgm();
    t_par();
    tally_and_finish();
  end
  initial
  begin
    #2000000;
    n_errors++;
    tally_and_finish();
  end
endmodule
